// *** dv/ddrmux_rx_model.sv ***
`timescale 1ns/1ps
// ---
// far side capture logic: rebuilds both words from the pair lines
// ---
module ddrmux_rx_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic fwd_clk_in,
	input wire logic [7:0] ch1_line_in,
	input wire logic [7:0] ch2_line_in,
	input wire logic flag_in,
	output logic [15:0] ch1_word_out,
	output logic [15:0] ch2_word_out,
	output logic ch1_flag_out,
	output logic ch2_flag_out
);
	logic fwd_prev_reg;
	logic [7:0] ch1_even_reg;
	logic [7:0] ch2_even_reg;
	logic ch2_flag_reg;
	// low phase: keep even bits and the channel two flag
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ch1_even_reg <= 8'h00;
			ch2_even_reg <= 8'h00;
			ch2_flag_reg <= 1'b0;
		end else if (!fwd_clk_in) begin
			ch1_even_reg <= ch1_line_in;
			ch2_even_reg <= ch2_line_in;
			ch2_flag_reg <= flag_in;
		end
	end
	// first high cycle shows the odd bits, so the word is whole only then
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fwd_prev_reg <= 1'b0;
			ch1_word_out <= 16'h0000;
			ch2_word_out <= 16'h0000;
			ch1_flag_out <= 1'b0;
			ch2_flag_out <= 1'b0;
		end else begin
			fwd_prev_reg <= fwd_clk_in;
			if (fwd_clk_in && !fwd_prev_reg) begin
				for (int k = 0; k < 8; k++) begin
					ch1_word_out[2*k] <= ch1_even_reg[k];
					ch1_word_out[2*k+1] <= ch1_line_in[k];
					ch2_word_out[2*k] <= ch2_even_reg[k];
					ch2_word_out[2*k+1] <= ch2_line_in[k];
				end
				ch1_flag_out <= flag_in;
				ch2_flag_out <= ch2_flag_reg;
			end
		end
	end
endmodule

// *** dv/test_dual_adc_ddr_output_mux.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
	$display("Error %0t: mismatch got %h exp %h", $time, got, exp); end end
// ---
// bench top
// ---
module test_dual_adc_ddr_output_mux;
	import ddrmux_pkg::*;
	int error_cnt = 0;
	int samples_checked = 0;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic enc = 1'b0;
	logic stab = 1'b0;
	logic strap = 1'b0;
	logic f1 = 1'b0;
	logic f2 = 1'b0;
	logic [1:0] mode = MODE_DDR_LVDS;
	logic [1:0] phase = PHASE_0;
	logic [SAMPLE_W-1:0] w1 = 16'h0000;
	logic [SAMPLE_W-1:0] w2 = 16'h0000;
	logic [33:0] exp_word = 34'h0;
	logic [PAIR_W-1:0] l1;
	logic [PAIR_W-1:0] l2;
	logic flag, fwd, fwd_b, act, rx_f1, rx_f2;
	logic [SAMPLE_W-1:0] rx_w1;
	logic [SAMPLE_W-1:0] rx_w2;
	ddrmux_top i_ddrmux_top (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .ce_in(1'b1), .encode_clk_in(enc),
		.ch1_result_in(w1), .ch2_result_in(w2), .ch1_over_range_in(f1), .ch2_over_range_in(f2),
		.out_mode_in(mode), .clk_phase_in(phase), .stabilizer_en_in(stab), .strap_config_in(strap),
		.ch1_pair_line_out(l1), .ch2_pair_line_out(l2), .shared_range_flag_out(flag),
		.fwd_sample_clock_out(fwd), .fwd_sample_clock_inv_out(fwd_b), .ddr_active_out(act));
	ddrmux_rx_model i_ddrmux_rx_model (.clk_in(ref_clk), .rst_b_in(rst_b), .fwd_clk_in(fwd),
		.ch1_line_in(l1), .ch2_line_in(l2), .flag_in(flag), .ch1_word_out(rx_w1), .ch2_word_out(rx_w2),
		.ch1_flag_out(rx_f1), .ch2_flag_out(rx_f2));
	// 50 MHz block clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	// both registered, so they must stay complementary; looked at mid-cycle where they are settled
	always @(negedge ref_clk) begin
		if (rst_b === 1'b1) `CHK(fwd_b, ~fwd)
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// one 160 ns encode period; the previous word is judged while this one is in flight
	task automatic sample(input logic [15:0] a, input logic [15:0] b, input logic fa, input logic fb, input bit chk);
		w1 = a;
		w2 = b;
		f1 = fa;
		f2 = fb;
		enc = 1'b1;
		tick(4);
		if (chk) `CHK({rx_f1, rx_f2, rx_w1, rx_w2}, exp_word)
		exp_word = {fa, fb, a, b};
		enc = 1'b0;
		tick(4);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic t_reset;
		`CHK({fwd, fwd_b, act, l1, l2, flag}, {3'b010, 17'h00000})
		$display("t_reset done");
	endtask
	// both ddr modes; the first sample only settles the latched mode, so the first two checks are off
	task automatic t_ddr;
		for (int m = 1; m < 3; m++) begin
			mode = m[1:0];
			sample(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
			sample(16'h0001, 16'h8000, 1'b1, 1'b0, 1'b0);
			sample(16'hAAAA, 16'h5555, 1'b0, 1'b1, 1'b1);
			sample(16'hFFFF, 16'h0000, 1'b1, 1'b1, 1'b1);
			sample(16'h1234, 16'hFEDC, 1'b0, 1'b0, 1'b1);
			`CHK(act, 1'b1)
		end
		$display("t_ddr done");
	endtask
	// under pin strap only the differential mode may run
	task automatic t_refused;
		strap = 1'b1;
		for (int c = 0; c < 4; c++) begin
			mode = c[1:0];
			sample(16'h6666, 16'h0000, 1'b0, 1'b0, 1'b0);
			sample(16'h6666, 16'h0000, 1'b0, 1'b0, 1'b0);
			`CHK({act, fwd, l1}, (c == 2) ? {2'b11, 8'h55} : 10'h000)
		end
		strap = 1'b0;
		$display("t_refused done");
	endtask
	// lag from odd data to the forwarded clock rise, in block cycles
	task automatic t_phase;
		int lag;
		int n;
		mode = MODE_DDR_LVDS;
		for (int c = 0; c < 5; c++) begin
			stab = (c < 4);
			phase = c[1:0] | {2{c == 4}};
			lag = 0;
			n = 0;
			sample(16'hAAAA, 16'h0000, 1'b0, 1'b0, 1'b0);
			fork
				repeat (2) sample(16'hAAAA, 16'h0000, 1'b0, 1'b0, 1'b0);
				begin
					while (l1 !== 8'h00 && n < 16) begin tick(1); n++; end
					while (l1 !== 8'hFF && n < 16) begin tick(1); n++; end
					while (fwd !== 1'b1 && lag < 8) begin tick(1); lag++; end
				end
			join
			if (n >= 16) begin
				error_cnt++;
				$display("Error %0t: odd data never seen", $time);
				return;
			end
			`CHK(lag, stab ? c : 0)
		end
		$display("t_phase done");
	endtask
	initial begin
		tick(10);
		t_reset();
		tick(10);
		rst_b = 1'b1;
		tick(4);
		t_ddr();
		t_refused();
		t_phase();
		complete_run();
	end
endmodule

// *** rtl/ddrmux_delay.sv ***
`timescale 1ns/1ps
// tapped shift line; used to push the forwarded clock behind the data
module ddrmux_delay #(
	parameter int TAPS = 8
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic d_in,
	output logic [TAPS-1:0] taps_out
);
	initial begin
		if (TAPS < 2) $error("delay line needs at least two taps");
	end
	// tap 0 is one cycle late, tap n is n+1 cycles late
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			taps_out <= '0;
		end else if (ce_in) begin
			taps_out <= {taps_out[TAPS-2:0], d_in};
		end
	end
endmodule

// *** rtl/ddrmux_pkg.sv ***
package ddrmux_pkg;
	// ----------------------------------------
	// widths and timing
	// ----------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int PAIR_W = 8;
	localparam int CLK_MHZ = 50;
	localparam int MAX_RATE_MSPS = 20;
	// phase shift settings of the forwarded clock, in eighths of a period
	localparam logic [1:0] PHASE_0 = 2'h0;
	localparam logic [1:0] PHASE_45 = 2'h1;
	localparam logic [1:0] PHASE_90 = 2'h2;
	localparam logic [1:0] PHASE_135 = 2'h3;
	// output modes
	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_DDR_CMOS = 2'h1;
	localparam logic [1:0] MODE_DDR_LVDS = 2'h2;
	// reset values and delay tap count
	localparam logic RST_BIT = 1'b0;
	localparam logic [SAMPLE_W-1:0] RST_WORD = 16'h0000;
	localparam int DELAY_TAPS = 8;
	typedef enum logic [2:0] {
		DDRMUX_IDLE = 3'b001,
		DDRMUX_LOW = 3'b010,
		DDRMUX_HIGH = 3'b100
	} ddrmux_phase_t;
endpackage

// *** rtl/ddrmux_sync.sv ***
`timescale 1ns/1ps
// two-stage synchroniser for a single level
module ddrmux_sync (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic d_in,
	output logic q_out
);
	logic meta_reg;
	// first stage is read only by the second
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_reg <= 1'b0;
			q_out <= 1'b0;
		end else if (ce_in) begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule

// *** rtl/ddrmux_top.sv ***
`timescale 1ns/1ps
// How it works
// - both channels sampled on one encode edge
// - one shared capture path keeps channels paired
// - eight pair lines per channel, even/odd bits
// - forwarded clock low shows even bits
// - forwarded clock high shows odd bits
// - range flag high on over or underrange
// - shared flag: channel two low, one high
// - differential mode shows channel two flag low
// - outputs change on both forwarded clock edges
// - inverted clock always complements forwarded clock
// - forwarded clock may lag data by setting
// - delay 45/90/135 only with stabilizer on
// - flag pipelined alongside its data
// - single-ended ddr refused under pin strap
module ddrmux_top #(
	parameter int SAMPLE_W = ddrmux_pkg::SAMPLE_W
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic encode_clk_in,
	input wire logic [ddrmux_pkg::SAMPLE_W-1:0] ch1_result_in,
	input wire logic [ddrmux_pkg::SAMPLE_W-1:0] ch2_result_in,
	input wire logic ch1_over_range_in,
	input wire logic ch2_over_range_in,
	input wire logic [1:0] out_mode_in,
	input wire logic [1:0] clk_phase_in,
	input wire logic stabilizer_en_in,
	input wire logic strap_config_in,
	output logic [ddrmux_pkg::PAIR_W-1:0] ch1_pair_line_out,
	output logic [ddrmux_pkg::PAIR_W-1:0] ch2_pair_line_out,
	output logic shared_range_flag_out,
	output logic fwd_sample_clock_out,
	output logic fwd_sample_clock_inv_out,
	output logic ddr_active_out
);
	import ddrmux_pkg::*;

	initial begin
		if (SAMPLE_W != 2 * PAIR_W) $error("sample width must be twice the pair line count");
	end

	// ----------------------------------------
	// reset release and encode clock sampling
	// ----------------------------------------
	logic rst_meta_reg;
	logic rst_b_reg;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_reg <= 1'b0;
			rst_b_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_b_reg <= rst_meta_reg;
		end
	end

	logic enc_sync;
	ddrmux_sync u_enc_sync (
		.clk_in(ref_clk_in),
		.rst_b_in(rst_b_reg),
		.ce_in(ce_in),
		.d_in(encode_clk_in),
		.q_out(enc_sync)
	);

	// edge finding happens only on the synchronised copy
	logic enc_prev_reg;
	logic enc_rise;
	logic enc_fall;
	always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			enc_prev_reg <= RST_BIT;
		end else if (ce_in) begin
			enc_prev_reg <= enc_sync;
		end
	end
	assign enc_rise = enc_sync & ~enc_prev_reg;
	assign enc_fall = ~enc_sync & enc_prev_reg;

	// ----------------------------------------
	// mode settings, taken once per encode rise
	// ----------------------------------------
	// results and modes are same-domain inputs; only the encode clock crosses
	logic [1:0] mode_reg;
	logic [1:0] phase_reg;
	logic ddr_mode;
	always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			mode_reg <= MODE_FULL;
			phase_reg <= PHASE_0;
		end else if (ce_in && enc_rise) begin
			// strap configuration cannot pick single-ended ddr; fall back to full rate
			if (strap_config_in && out_mode_in == MODE_DDR_CMOS) begin
				mode_reg <= MODE_FULL;
			end else begin
				mode_reg <= out_mode_in;
			end
			// phase shift needs the stabilizer; otherwise it stays at zero
			phase_reg <= stabilizer_en_in ? clk_phase_in : PHASE_0;
		end
	end
	assign ddr_mode = (mode_reg == MODE_DDR_CMOS) || (mode_reg == MODE_DDR_LVDS);

	// ----------------------------------------
	// shared capture of both channels and flags
	// ----------------------------------------
	// one enable for both words and both flags so they never drift apart
	logic [SAMPLE_W-1:0] ch1_word_reg;
	logic [SAMPLE_W-1:0] ch2_word_reg;
	logic ch1_flag_reg;
	logic ch2_flag_reg;
	always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			ch1_word_reg <= RST_WORD;
			ch2_word_reg <= RST_WORD;
			ch1_flag_reg <= RST_BIT;
			ch2_flag_reg <= RST_BIT;
		end else if (ce_in && enc_rise) begin
			ch1_word_reg <= ch1_result_in;
			ch2_word_reg <= ch2_result_in;
			ch1_flag_reg <= ch1_over_range_in;
			ch2_flag_reg <= ch2_over_range_in;
		end
	end

	// ----------------------------------------
	// output phase state machine
	// ----------------------------------------
	// low phase follows the encode rise, high phase the encode fall
	ddrmux_phase_t phase_state_reg;
	ddrmux_phase_t phase_state_next;
	always_comb begin
		phase_state_next = phase_state_reg;
		unique case (phase_state_reg)
			DDRMUX_IDLE: begin
				if (enc_rise) phase_state_next = DDRMUX_LOW;
			end
			DDRMUX_LOW: begin
				if (enc_fall) phase_state_next = DDRMUX_HIGH;
			end
			DDRMUX_HIGH: begin
				if (enc_rise) phase_state_next = DDRMUX_LOW;
			end
		endcase
	end
	always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			phase_state_reg <= DDRMUX_IDLE;
		end else if (ce_in) begin
			phase_state_reg <= phase_state_next;
		end
	end

	// phase copy one cycle late: low while even bits stand, high while odd bits stand
	// it feeds the taps; phase 0 takes the value from the next state directly
	logic clk_base_reg;
	always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			clk_base_reg <= RST_BIT;
		end else if (ce_in) begin
			clk_base_reg <= (phase_state_next == DDRMUX_HIGH);
		end
	end

	// ----------------------------------------
	// data and flag multiplexing
	// ----------------------------------------
	// each line picks bit 2k when low, 2k+1 when high, updated on both phases
	genvar gi;
	generate
		for (gi = 0; gi < PAIR_W; gi++) begin : g_pair
			always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
				if (!rst_b_reg) begin
					ch1_pair_line_out[gi] <= RST_BIT;
					ch2_pair_line_out[gi] <= RST_BIT;
				end else if (ce_in) begin
					if (!ddr_mode) begin
						// full-rate pins are outside this block; hold lines low
						ch1_pair_line_out[gi] <= RST_BIT;
						ch2_pair_line_out[gi] <= RST_BIT;
					end else if (phase_state_next == DDRMUX_HIGH) begin
						ch1_pair_line_out[gi] <= ch1_word_reg[2*gi+1];
						ch2_pair_line_out[gi] <= ch2_word_reg[2*gi+1];
					end else begin
						ch1_pair_line_out[gi] <= ch1_word_reg[2*gi];
						ch2_pair_line_out[gi] <= ch2_word_reg[2*gi];
					end
				end
			end
		end
	endgenerate

	// shared flag switches with the same phase as the data
	always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			shared_range_flag_out <= RST_BIT;
		end else if (ce_in) begin
			if (!ddr_mode) begin
				shared_range_flag_out <= RST_BIT;
			end else if (phase_state_next == DDRMUX_HIGH) begin
				shared_range_flag_out <= ch1_flag_reg;
			end else begin
				shared_range_flag_out <= ch2_flag_reg;
			end
		end
	end

	// ----------------------------------------
	// forwarded clock delay and its complement
	// ----------------------------------------
	// delay granularity is one ref cycle, so degrees are approximate at low rates
	// only the first taps are used; the line stays general for longer lags
	logic [DELAY_TAPS-1:0] clk_taps;
	ddrmux_delay #(
		.TAPS(DELAY_TAPS)
	) u_clk_delay (
		.clk_in(ref_clk_in),
		.rst_b_in(rst_b_reg),
		.ce_in(ce_in),
		.d_in(clk_base_reg),
		.taps_out(clk_taps)
	);
	logic clk_delayed;
	always_comb begin
		unique case (phase_reg)
			PHASE_0: clk_delayed = (phase_state_next == DDRMUX_HIGH);
			PHASE_45: clk_delayed = clk_base_reg;
			PHASE_90: clk_delayed = clk_taps[0];
			PHASE_135: clk_delayed = clk_taps[1];
		endcase
	end
	// both pins come from one flop pair fed by one value, so they never agree
	always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
		if (!rst_b_reg) begin
			fwd_sample_clock_out <= 1'b0;
			fwd_sample_clock_inv_out <= 1'b1;
			ddr_active_out <= 1'b0;
		end else if (ce_in) begin
			fwd_sample_clock_out <= clk_delayed & ddr_mode;
			fwd_sample_clock_inv_out <= ~(clk_delayed & ddr_mode);
			ddr_active_out <= ddr_mode;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// the edge at which words, flags and settings are all taken
	sequence s_rise_seen;
		ce_in && enc_rise;
	endsequence

	a_clock_complement: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		fwd_sample_clock_inv_out == !fwd_sample_clock_out)
		else $error("inverted clock not complementary");

	a_even_on_low: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		ce_in && ddr_mode && phase_state_next == DDRMUX_LOW |=> ch1_pair_line_out[0] == $past(ch1_word_reg[0]))
		else $error("even bit missing in low phase");

	a_odd_on_high: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		ce_in && ddr_mode && phase_state_next == DDRMUX_HIGH |=> ch2_pair_line_out[7] == $past(ch2_word_reg[15]))
		else $error("odd bit missing in high phase");

	a_flag_ch2_low: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		ce_in && ddr_mode && phase_state_next == DDRMUX_LOW |=> shared_range_flag_out == $past(ch2_flag_reg))
		else $error("channel two flag not shown in low phase");

	a_flag_ch1_high: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		ce_in && ddr_mode && phase_state_next == DDRMUX_HIGH |=> shared_range_flag_out == $past(ch1_flag_reg))
		else $error("channel one flag not shown in high phase");

	a_shared_capture: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		s_rise_seen |=> ch1_word_reg == $past(ch1_result_in) && ch2_word_reg == $past(ch2_result_in)
			&& ch1_flag_reg == $past(ch1_over_range_in))
		else $error("channels not captured together");

	a_no_phase_unstab: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		(s_rise_seen and !stabilizer_en_in) |=> phase_reg == PHASE_0)
		else $error("phase shift active without stabilizer");

	a_strap_no_cmos: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		(s_rise_seen and strap_config_in) |=> mode_reg != MODE_DDR_CMOS)
		else $error("single-ended ddr chosen under strap");

	a_flag_with_data: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		s_rise_seen |=> ch2_flag_reg == $past(ch2_over_range_in) && ch2_word_reg == $past(ch2_result_in))
		else $error("range flag not taken with its sample");

	a_lvds_flag_low: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		ce_in && mode_reg == MODE_DDR_LVDS && phase_state_next == DDRMUX_LOW |=> shared_range_flag_out == $past(ch2_flag_reg))
		else $error("differential mode lacks channel two flag in low phase");

	a_clock_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_b_reg)
		ce_in && ddr_mode && phase_reg == PHASE_0 |=> fwd_sample_clock_out == clk_base_reg)
		else $error("forwarded clock does not follow data phase");
endmodule
